/* rtl/gpio_event_map.svh */
/*
  constants of the gpio event-detect block: pin counts, register
  offsets, reset values and bus encodings.
  assumes inclusion by bare name from every design file.
*/
// Function
// [RL1] high-level enable sets status while pin high
// [RL2] status stays set while high level persists
// [RL3] low-level enable sets status while pin low
// [RL4] status stays set while low level persists
// [RL5] async rising edge sets status, no sampling
// [RL6] async capture keeps pulses shorter than clock
// [RL7] async falling edge sets status, no sampling
// [RL8] bank1 sync fall enables bits 25:0 only
// [RL9] bank0 enables map to pins 0-31
// [RL10] bank1 enables map to pins 32-57
// [RL11] zero disables; enables reset to zero (the interrupt enables here reset to all ones)
// [RL12] sync fall reports sampled 1,0,0 only
// [RL13] write one clears status; zero keeps
// [RL14] per-bank interrupts plus any-bit interrupt
// [RL15] pin-clocked capture, synchronised, clear-free toggle
`ifndef GPIO_EVENT_MAP_SVH
`define GPIO_EVENT_MAP_SVH

`define NPIN 58
`define B0W 32
`define B1W 26
`define B1LO 32
`define AOFF_W 12

`define OFF_HIGH_EN0 12'h000
`define OFF_HIGH_EN1 12'h004
`define OFF_LOW_EN0 12'h008
`define OFF_LOW_EN1 12'h00C
`define OFF_ARISE_EN0 12'h010
`define OFF_ARISE_EN1 12'h014
`define OFF_AFALL_EN0 12'h018
`define OFF_AFALL_EN1 12'h01C
`define OFF_SFALL_EN1 12'h020
`define OFF_STATUS0 12'h024
`define OFF_STATUS1 12'h028
`define OFF_IRQ_EN0 12'h02C
`define OFF_IRQ_EN1 12'h030
`define OFF_CLEAR0 12'h034
`define OFF_CLEAR1 12'h038

`define EN_RST0 32'h0000_0000
`define EN_RST1 26'h000_0000
`define IRQ_EN_RST0 32'hFFFF_FFFF
`define IRQ_EN_RST1 26'h3FF_FFFF
`define RD_ZERO 32'h0000_0000

`define HTRANS_XFER_BIT 1
`define HRESP_OKAY 1'b0

`endif

/* rtl/gpio_event_pkg.sv */
/*
  types of the gpio event-detect block: bus phase enum and the
  packed state of each module.
  assumes gpio_event_map.svh is on the include path.
*/
`include "gpio_event_map.svh"

package gpio_event_pkg;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_READ = 2'b01,
    PH_WRITE = 2'b10
  } bus_ph_e;

  typedef struct packed {
    logic [`B1W-1:0] s0;
    logic [`B1W-1:0] s1;
    logic [`B1W-1:0] s2;
  } sfall_state_s;

  typedef struct packed {
    logic [`NPIN-1:0] r1;
    logic [`NPIN-1:0] r2;
    logic [`NPIN-1:0] r3;
    logic [`NPIN-1:0] f1;
    logic [`NPIN-1:0] f2;
    logic [`NPIN-1:0] f3;
  } async_state_s;

  typedef struct packed {
    logic [`B0W-1:0] hen0;
    logic [`B0W-1:0] len0;
    logic [`B0W-1:0] aren0;
    logic [`B0W-1:0] afen0;
    logic [`B0W-1:0] irqen0;
    logic [`B0W-1:0] sts0;
    logic [`B1W-1:0] fen1;
    logic [`B1W-1:0] hen1;
    logic [`B1W-1:0] len1;
    logic [`B1W-1:0] aren1;
    logic [`B1W-1:0] afen1;
    logic [`B1W-1:0] irqen1;
    logic [`B1W-1:0] sts1;
    bus_ph_e ph;
    logic [`AOFF_W-1:0] addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq0;
    logic irq1;
    logic irq_any;
  } top_state_s;

endpackage

/* rtl/gpio_evt_if.sv */
/*
  carrier between the top and its two detector modules.
  assumes all signals are driven by exactly one modport owner.
*/
`timescale 1ns/1ps
`include "gpio_event_map.svh"

interface gpio_evt_if;
  logic [`NPIN-1:0] pin;
  logic [`NPIN-1:0] arise_evt;
  logic [`NPIN-1:0] afall_evt;
  logic [`B1W-1:0] sfall_evt;
  modport top (output pin, input arise_evt, afall_evt, sfall_evt);
  modport acap (input pin, output arise_evt, afall_evt);
  modport sfd (input pin, output sfall_evt);
endinterface

/* rtl/sync_fall_detect.sv */
/*
  synchronous falling-edge detector for pins 32-57.
  assumes pins are synchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "gpio_event_map.svh"

module sync_fall_detect
  import gpio_event_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  gpio_evt_if.sfd evt
);

  sfall_state_s st;
  sfall_state_s next_st;

  always_comb begin
    next_st.s0 = evt.pin[`NPIN-1:`B1LO];
    next_st.s1 = st.s0;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // oldest sample high, two newer low
  assign evt.sfall_evt = st.s2 & ~st.s1 & ~st.s0; // RL12

endmodule

/* rtl/async_edge_capture.sv */
/*
  asynchronous edge capture: each pin edge flips a toggle clocked by
  the pin itself; the toggles cross into ref_clk by two flip-flops
  and a change becomes a one-cycle event pulse.
  assumes rst_n is released synchronously to ref_clk.
*/
`timescale 1ns/1ps
`include "gpio_event_map.svh"

module async_edge_capture
  import gpio_event_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  gpio_evt_if.acap evt
);

  logic [`NPIN-1:0] rtog;
  logic [`NPIN-1:0] ftog;
  async_state_s st;
  async_state_s next_st;

  // ****************************************
  // pin-clocked toggles
  // ****************************************
  for (genvar i = 0; i < `NPIN; i++) begin : g_pin
    logic rt;
    logic ft;
    always_ff @(posedge evt.pin[i] or negedge rst_n) begin
      if (!rst_n) begin
        rt <= 1'b0;
      end else begin
        rt <= ~rt; // RL5 RL6 RL15
      end
    end
    always_ff @(negedge evt.pin[i] or negedge rst_n) begin
      if (!rst_n) begin
        ft <= 1'b0;
      end else begin
        ft <= ~ft; // RL7 RL6 RL15
      end
    end
    assign rtog[i] = rt;
    assign ftog[i] = ft;
  end

  // ****************************************
  // crossing into ref_clk
  // ****************************************
  always_comb begin
    next_st.r1 = rtog;
    next_st.r2 = st.r1;
    next_st.r3 = st.r2;
    next_st.f1 = ftog;
    next_st.f2 = st.f1;
    next_st.f3 = st.f2;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // toggle change means one edge seen; nothing needs clearing
  assign evt.arise_evt = st.r2 ^ st.r3; // RL15
  assign evt.afall_evt = st.f2 ^ st.f3; // RL15

endmodule

/* rtl/gpio_event_detect.sv */
/*
  gpio event-detect block: enable registers, sticky event status,
  interrupt enables and outputs, reached over an ahb-lite slave.
  the two detector modules feed one-cycle edge pulses; level
  detection and the set-over-clear status update live here.
  bank1 registers keep 26 bits; the upper bits read as zero.
  assumes pin_in synchronous to ref_clk (async edge paths aside),
  single word transfers, and a single slave on the bus.
  assumes the master waits out the one read wait state and
  presents write data in the cycle after the address.
*/
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "gpio_event_map.svh"

module gpio_event_detect
  import gpio_event_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [`NPIN-1:0] pin_in,
  output logic irq_bank0,
  output logic irq_bank1,
  output logic irq_any
);

  // ****************************************
  // detectors
  // ****************************************
  gpio_evt_if evt ();

  assign evt.pin = pin_in;

  async_edge_capture u_acap (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .evt(evt)
  );

  sync_fall_detect u_sfd (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .evt(evt)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] evt_set(
    input logic [31:0] pin,
    input logic [31:0] hen,
    input logic [31:0] len,
    input logic [31:0] aren,
    input logic [31:0] afen,
    input logic [31:0] arise,
    input logic [31:0] afall,
    input logic [31:0] fen,
    input logic [31:0] sfall
  );
    logic [31:0] s;
    s = hen & pin; // RL1
    s = s | (len & ~pin); // RL3
    s = s | (aren & arise); // RL5
    s = s | (afen & afall); // RL7
    s = s | (fen & sfall); // RL12
    return s;
  endfunction

  function automatic logic [31:0] clr_mask(
    input logic wr,
    input logic [`AOFF_W-1:0] a,
    input logic [`AOFF_W-1:0] sts_off,
    input logic [`AOFF_W-1:0] clr_off,
    input logic [31:0] wd
  );
    logic hit;
    hit = wr && (a == sts_off || a == clr_off);
    return hit ? wd : `RD_ZERO; // RL13
  endfunction

  function automatic logic [31:0] bank1_word(
    input logic [`B1W-1:0] v
  );
    return 32'(v);
  endfunction

  function automatic logic [`B1W-1:0] bank1_bits(
    input logic [31:0] w
  );
    return w[`B1W-1:0]; // RL8
  endfunction

  function automatic logic irq_of(
    input logic [31:0] sts,
    input logic [31:0] en
  );
    return |(sts & en); // RL14
  endfunction

  function automatic logic [31:0] sts_next(
    input logic [31:0] sts,
    input logic [31:0] clr,
    input logic [31:0] set
  );
    return (sts & ~clr) | set; // RL2 RL4 RL13
  endfunction

  // ****************************************
  // state
  // ****************************************
  top_state_s st;
  top_state_s next_st;
  logic accept;
  logic wr_now;
  logic [31:0] set0;
  logic [31:0] set1;
  logic [31:0] clr0;
  logic [31:0] clr1;
  logic [31:0] pin_b0;
  logic [31:0] pin_b1;
  logic [31:0] arise_b0;
  logic [31:0] arise_b1;
  logic [31:0] afall_b0;
  logic [31:0] afall_b1;
  logic [31:0] sfall_b1;
  logic [`AOFF_W-1:0] aoff;

  // ****************************************
  // bus handshake
  // ****************************************
  assign accept = hsel && htrans[`HTRANS_XFER_BIT] && hready;
  assign wr_now = (st.ph == PH_WRITE);
  assign aoff = haddr[`AOFF_W-1:0];

  // ****************************************
  // bank split
  // ****************************************
  assign pin_b0 = pin_in[`B0W-1:0]; // RL9
  assign pin_b1 = bank1_word(pin_in[`NPIN-1:`B1LO]); // RL10
  assign arise_b0 = evt.arise_evt[`B0W-1:0];
  assign arise_b1 = bank1_word(evt.arise_evt[`NPIN-1:`B1LO]);
  assign afall_b0 = evt.afall_evt[`B0W-1:0];
  assign afall_b1 = bank1_word(evt.afall_evt[`NPIN-1:`B1LO]);
  assign sfall_b1 = bank1_word(evt.sfall_evt);

  always_comb begin
    set0 = evt_set(
      pin_b0,
      st.hen0,
      st.len0,
      st.aren0,
      st.afen0,
      arise_b0,
      afall_b0,
      `RD_ZERO,
      `RD_ZERO
    ); // RL9
    set1 = evt_set(
      pin_b1,
      bank1_word(st.hen1),
      bank1_word(st.len1),
      bank1_word(st.aren1),
      bank1_word(st.afen1),
      arise_b1,
      afall_b1,
      bank1_word(st.fen1),
      sfall_b1
    ); // RL10
    clr0 = clr_mask(wr_now, st.addr, `OFF_STATUS0, `OFF_CLEAR0,
      hwdata);
    clr1 = clr_mask(wr_now, st.addr, `OFF_STATUS1, `OFF_CLEAR1,
      hwdata);
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.hresp = `HRESP_OKAY;
    // ------------------------------------------
    // write data phase
    // ------------------------------------------
    if (wr_now) begin
      unique case (st.addr)
        `OFF_HIGH_EN0: begin
          next_st.hen0 = hwdata; // RL9
        end
        `OFF_HIGH_EN1: begin
          next_st.hen1 = hwdata[`B1W-1:0]; // RL10
        end
        `OFF_LOW_EN0: begin
          next_st.len0 = hwdata;
        end
        `OFF_LOW_EN1: begin
          next_st.len1 = hwdata[`B1W-1:0];
        end
        `OFF_ARISE_EN0: begin
          next_st.aren0 = hwdata;
        end
        `OFF_ARISE_EN1: begin
          next_st.aren1 = hwdata[`B1W-1:0];
        end
        `OFF_AFALL_EN0: begin
          next_st.afen0 = hwdata;
        end
        `OFF_AFALL_EN1: begin
          next_st.afen1 = hwdata[`B1W-1:0];
        end
        `OFF_SFALL_EN1: begin
          next_st.fen1 = hwdata[`B1W-1:0]; // RL8
        end
        `OFF_IRQ_EN0: begin
          next_st.irqen0 = hwdata;
        end
        `OFF_IRQ_EN1: begin
          next_st.irqen1 = hwdata[`B1W-1:0];
        end
        default: begin
        end
      endcase
    end
    // ------------------------------------------
    // sticky status: set wins over clear
    // ------------------------------------------
    next_st.sts0 = sts_next(st.sts0, clr0, set0); // RL2 RL4 RL13
    next_st.sts1 = bank1_bits(
      sts_next(bank1_word(st.sts1), clr1, set1)); // RL2 RL4 RL13
    // ------------------------------------------
    // read wait cycle and address phase
    // ------------------------------------------
    if (st.ph == PH_READ) begin
      unique case (st.addr)
        `OFF_HIGH_EN0: begin
          next_st.hrdata = st.hen0;
        end
        `OFF_HIGH_EN1: begin
          next_st.hrdata = bank1_word(st.hen1);
        end
        `OFF_LOW_EN0: begin
          next_st.hrdata = st.len0;
        end
        `OFF_LOW_EN1: begin
          next_st.hrdata = bank1_word(st.len1);
        end
        `OFF_ARISE_EN0: begin
          next_st.hrdata = st.aren0;
        end
        `OFF_ARISE_EN1: begin
          next_st.hrdata = bank1_word(st.aren1);
        end
        `OFF_AFALL_EN0: begin
          next_st.hrdata = st.afen0;
        end
        `OFF_AFALL_EN1: begin
          next_st.hrdata = bank1_word(st.afen1);
        end
        `OFF_SFALL_EN1: begin
          next_st.hrdata = bank1_word(st.fen1); // RL8
        end
        `OFF_STATUS0: begin
          next_st.hrdata = st.sts0;
        end
        `OFF_STATUS1: begin
          next_st.hrdata = bank1_word(st.sts1);
        end
        `OFF_IRQ_EN0: begin
          next_st.hrdata = st.irqen0;
        end
        `OFF_IRQ_EN1: begin
          next_st.hrdata = bank1_word(st.irqen1);
        end
        default: begin
          next_st.hrdata = `RD_ZERO;
        end
      endcase
      next_st.hreadyout = 1'b1;
      next_st.ph = PH_IDLE;
    end else if (accept) begin
      next_st.addr = aoff;
      next_st.ph = hwrite ? PH_WRITE : PH_READ;
      next_st.hreadyout = hwrite;
    end else begin
      next_st.ph = PH_IDLE;
      next_st.hreadyout = 1'b1;
    end
    // ------------------------------------------
    // interrupts
    // ------------------------------------------
    next_st.irq0 = irq_of(next_st.sts0, next_st.irqen0); // RL14
    next_st.irq1 = irq_of(bank1_word(next_st.sts1),
      bank1_word(next_st.irqen1)); // RL14
    next_st.irq_any = next_st.irq0 | next_st.irq1; // RL14
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st.hen0 <= `EN_RST0; // RL11
      st.len0 <= `EN_RST0;
      st.aren0 <= `EN_RST0;
      st.afen0 <= `EN_RST0;
      st.irqen0 <= `IRQ_EN_RST0;
      st.sts0 <= `EN_RST0;
      st.fen1 <= `EN_RST1;
      st.hen1 <= `EN_RST1;
      st.len1 <= `EN_RST1;
      st.aren1 <= `EN_RST1;
      st.afen1 <= `EN_RST1;
      st.irqen1 <= `IRQ_EN_RST1;
      st.sts1 <= `EN_RST1;
      st.ph <= PH_IDLE;
      st.addr <= '0;
      st.hrdata <= `RD_ZERO;
      st.hreadyout <= 1'b1;
      st.hresp <= `HRESP_OKAY;
      st.irq0 <= 1'b0;
      st.irq1 <= 1'b0;
      st.irq_any <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign hrdata = st.hrdata;
  assign hreadyout = st.hreadyout;
  assign hresp = st.hresp;
  assign irq_bank0 = st.irq0;
  assign irq_bank1 = st.irq1;
  assign irq_any = st.irq_any;

endmodule

/* verif/gpio_event_checker_assertions.sv */
/*
  port checker of the gpio event-detect top.
  assumes binding onto gpio_event_detect, one clock, sync reset.
*/
`timescale 1ns/1ps
`include "gpio_event_map.svh"

module gpio_event_checker
  import gpio_event_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [`NPIN-1:0] pin_in,
  input wire logic irq_bank0,
  input wire logic irq_bank1,
  input wire logic irq_any
);
  // ***********************************
  // bus snoop of bank0 enables
  // ***********************************
  logic wp;
  logic [11:0] wa;
  logic [31:0] hen0, len0, ie0;
  logic rd_take, wr_take;
  logic [31:0] ie0_nx;
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  assign wr_take = hsel && htrans[1] && hready && hwrite;
  // interrupt enable as it stands after this edge
  assign ie0_nx = (wp && wa == `OFF_IRQ_EN0) ? hwdata : ie0;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wp <= 1'b0;
      wa <= 12'h000;
      hen0 <= 32'h0000_0000;
      len0 <= 32'h0000_0000;
      ie0 <= 32'hFFFF_FFFF;
    end else begin
      wp <= wr_take;
      wa <= haddr[11:0];
      if (wp && wa == `OFF_HIGH_EN0) hen0 <= hwdata;
      if (wp && wa == `OFF_LOW_EN0) len0 <= hwdata;
      if (wp && wa == `OFF_IRQ_EN0) ie0 <= hwdata;
    end
  end
  // ***********************************
  // assertions
  // ***********************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_RD_WAIT: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_WR_NOWAIT: assert property (wr_take |=> hreadyout)
    else $error("write stalled");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("response not okay");
  AST_RST: assert property ($rose(rst_n) |-> !irq_any && hreadyout)
    else $error("state after reset wrong");
  AST_ANY: assert property (irq_any == (irq_bank0 || irq_bank1))
    else $error("any-interrupt mismatch");
  AST_HIGH: assert property (
    |(hen0 & pin_in[31:0] & ie0_nx) |-> ##[1:3] irq_bank0)
    else $error("high level missed");
  AST_HOLD: assert property (
    |(hen0 & pin_in[31:0] & ie0_nx) [*2] |=> irq_bank0)
    else $error("high level not held");
  AST_LOW: assert property (
    |(len0 & ~pin_in[31:0] & ie0_nx) |-> ##[1:3] irq_bank0)
    else $error("low level missed");
  AST_MASK: assert property (
    (ie0 == 32'h0000_0000) [*2] |-> !irq_bank0)
    else $error("masked interrupt high");
endmodule

/* verif/pin_source.sv */
/*
  far-side model: external pins driving the gpio inputs.
  assumes the bench calls its tasks right after a clock edge.
*/
`timescale 1ns/1ps
`include "gpio_event_map.svh"

module pin_source (
  output logic [`NPIN-1:0] pins
);
  initial pins = '0;
  task drive(input int n, input logic v);
    pins[n] <= v;
  endtask
  // pulse far shorter than a clock period
  task glitch(input int n, input int w);
    pins[n] = ~pins[n];
    #w;
    pins[n] = ~pins[n];
  endtask
endmodule

/* verif/testbench.sv */
/*
  self-checking bench of the gpio event-detect block.
  assumes the design files and pin_source compiled before it.
*/
`timescale 1ns/1ps
`include "gpio_event_map.svh"

module testbench;
  import gpio_event_pkg::*;
  logic ref_clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic irq_bank0, irq_bank1, irq_any;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [`NPIN-1:0] pin_in;
  int bad_count, total_checks;
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("Error t=%0t got=%h exp=%h", $time, g, e); end end

  gpio_event_detect u_gpio_event_detect (.ref_clk(ref_clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
    .irq_bank0(irq_bank0), .irq_bank1(irq_bank1), .irq_any(irq_any));
  pin_source u_pin_source (.pins(pin_in));

  // ***********************************
  // bus tasks
  // ***********************************
  task end_sim;
    $display("checks=%0d errors=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task rdy;
    int i;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 20);
    if (i >= 20) begin
      bad_count++;
      end_sim;
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= 1'b1;
    haddr <= {20'h0_0000, a};
    rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy;
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= 1'b0;
    haddr <= {20'h0_0000, a};
    rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    rdy;
    `CHK(hrdata, e)
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // ***********************************
  // scenarios
  // ***********************************
  task t_reset;
    for (int i = 0; i < 9; i++) rc(12'(i * 4), `RD_ZERO);
    rc(`OFF_IRQ_EN0, 32'hFFFF_FFFF);
    rc(12'h100, `RD_ZERO);
    `CHK(irq_any, 1'b0)
  endtask
  task t_level;
    wr(`OFF_HIGH_EN0, 32'h0000_0008);
    u_pin_source.drive(3, 1'b1);
    cyc(3);
    rc(`OFF_STATUS0, 32'h0000_0008);
    `CHK(irq_bank0, 1'b1)
    wr(`OFF_STATUS0, 32'h0000_0008);
    rc(`OFF_STATUS0, 32'h0000_0008);
    wr(`OFF_IRQ_EN0, `RD_ZERO);
    cyc(2);
    `CHK(irq_bank0, 1'b0)
    wr(`OFF_IRQ_EN0, 32'hFFFF_FFFF);
    u_pin_source.drive(3, 1'b0);
    cyc(2);
    wr(`OFF_STATUS0, `RD_ZERO);
    rc(`OFF_STATUS0, 32'h0000_0008);
    wr(`OFF_HIGH_EN0, `RD_ZERO);
    wr(`OFF_STATUS0, 32'h0000_0008);
    rc(`OFF_STATUS0, `RD_ZERO);
    wr(`OFF_LOW_EN0, 32'h0000_0001);
    cyc(3);
    rc(`OFF_STATUS0, 32'h0000_0001);
    wr(`OFF_LOW_EN0, `RD_ZERO);
    wr(`OFF_STATUS0, 32'h0000_0001);
    wr(`OFF_LOW_EN1, 32'h0000_0100);
    cyc(3);
    rc(`OFF_STATUS1, 32'h0000_0100);
    `CHK({irq_bank1, irq_any}, 2'b11)
    wr(`OFF_CLEAR1, 32'h0000_0100);
    rc(`OFF_STATUS1, 32'h0000_0100);
    u_pin_source.drive(40, 1'b1);
    cyc(2);
    wr(`OFF_CLEAR1, 32'h0000_0100);
    rc(`OFF_STATUS1, `RD_ZERO);
    wr(`OFF_LOW_EN1, `RD_ZERO);
  endtask
  task t_sfall;
    wr(`OFF_SFALL_EN1, 32'hFFFF_FFFF);
    rc(`OFF_SFALL_EN1, 32'h03FF_FFFF);
    u_pin_source.drive(33, 1'b1);
    cyc(4);
    u_pin_source.drive(33, 1'b0);
    cyc(1);
    u_pin_source.drive(33, 1'b1);
    cyc(8);
    rc(`OFF_STATUS1, `RD_ZERO);
    u_pin_source.drive(33, 1'b0);
    cyc(8);
    rc(`OFF_STATUS1, 32'h0000_0002);
    wr(`OFF_CLEAR1, 32'h0000_0002);
    wr(`OFF_SFALL_EN1, `RD_ZERO);
  endtask
  task t_async;
    wr(`OFF_ARISE_EN0, 32'h0000_0020);
    #7 u_pin_source.glitch(5, 5);
    cyc(6);
    rc(`OFF_STATUS0, 32'h0000_0020);
    wr(`OFF_STATUS0, 32'h0000_0020);
    wr(`OFF_ARISE_EN0, `RD_ZERO);
    #7 u_pin_source.glitch(5, 5);
    cyc(6);
    rc(`OFF_STATUS0, `RD_ZERO);
    wr(`OFF_AFALL_EN1, 32'h0000_0004);
    #7 u_pin_source.glitch(34, 5);
    cyc(6);
    rc(`OFF_STATUS1, 32'h0000_0004);
    wr(`OFF_CLEAR1, 32'h0000_0004);
  endtask

  // ***********************************
  // clock, reset, sequence
  // ***********************************
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    bad_count = 0;
    total_checks = 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset;
    t_level;
    t_sfall;
    t_async;
    end_sim;
  end
endmodule

bind gpio_event_detect gpio_event_checker u_gpio_event_checker (
  .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
  .irq_bank0(irq_bank0), .irq_bank1(irq_bank1), .irq_any(irq_any));
